// *** core/pump_detector_pkg.sv ***
package pump_detector_pkg;

    // ======================================================================
    // register port geometry
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;

    localparam logic [ADDR_W-1:0] ADDR_PUMP_CURRENT_CONFIG = 6'h09;
    localparam logic [ADDR_W-1:0] ADDR_PUMP_AMPLIFIER_BIAS = 6'h0a;
    localparam logic [ADDR_W-1:0] ADDR_PHASE_DETECTOR_CONTROL = 6'h0b;

    // ======================================================================
    // pump_current_config field positions
    localparam int PC_RSVD_LO_LSB = 0;
    localparam int PC_RSVD_LO_W = 2;
    localparam int PC_UP_OFFSET_LSB = 2;
    localparam int PC_RSVD_MID_LSB = 5;
    localparam int PC_RSVD_MID_W = 2;
    localparam int PC_DOWN_OFFSET_LSB = 7;
    localparam int PC_UP_TRIM_LSB = 10;
    localparam int PC_DOWN_TRIM_LSB = 14;
    localparam int PC_UP_MAIN_LSB = 18;
    localparam int PC_DOWN_MAIN_LSB = 21;
    localparam int OFFSET_W = 3;
    localparam int TRIM_W = 4;
    localparam int MAIN_W = 3;

    // pump_amplifier_bias field
    localparam int AB_BIAS_LSB = 0;
    localparam int BIAS_W = 2;

    // phase_detector_control field positions
    localparam int PD_DELAY_LSB = 0;
    localparam int DELAY_W = 3;
    localparam int PD_SWAP_BIT = 3;
    localparam int PD_UP_EN_BIT = 4;
    localparam int PD_DOWN_EN_BIT = 5;
    localparam int PD_LOCK_PIN_EN_BIT = 6;
    localparam int PD_FORCE_UP_BIT = 7;
    localparam int PD_FORCE_DOWN_BIT = 8;
    localparam int PD_MUTE_LOCKED_BIT = 9;

    // ======================================================================
    // reset values
    localparam logic [OFFSET_W-1:0] RST_OFFSET = 3'h0;
    localparam logic [TRIM_W-1:0] RST_TRIM = 4'h0;
    localparam logic [MAIN_W-1:0] RST_MAIN = 3'h0;
    localparam logic [BIAS_W-1:0] RST_BIAS = 2'h0;
    localparam logic [DELAY_W-1:0] RST_DELAY = 3'h0;
    localparam logic RST_SWAP = 1'b0;
    localparam logic RST_UP_EN = 1'b1;
    localparam logic RST_DOWN_EN = 1'b1;
    localparam logic RST_LOCK_PIN_EN = 1'b1;
    localparam logic RST_FORCE = 1'b0;
    localparam logic RST_MUTE_LOCKED = 1'b0;
    localparam logic [DELAY_W-1:0] DELAY_TOO_SHORT = 3'h0;

    // ======================================================================
    // current scales in microamperes
    localparam int OFFSET_UA_W = 9;
    localparam int TRIM_UA_W = 7;
    localparam int MAIN_UA_W = 12;
    localparam int BIAS_UA_W = 11;
    localparam logic [OFFSET_UA_W-1:0] OFFSET_STEP_UA = 9'h037;
    localparam logic [TRIM_UA_W-1:0] TRIM_STEP_UA = 7'h07;
    localparam logic [MAIN_UA_W-1:0] MAIN_STEP_UA = 12'h1f4;
    localparam logic [MAIN_UA_W-1:0] MAIN_MAX_UA = 12'h7d0;
    localparam logic [MAIN_W-1:0] MAIN_SAT_CODE = 3'h4;
    localparam logic [BIAS_UA_W-1:0] BIAS_UA_0 = 11'h21c;
    localparam logic [BIAS_UA_W-1:0] BIAS_UA_1 = 11'h2b1;
    localparam logic [BIAS_UA_W-1:0] BIAS_UA_2 = 11'h3af;
    localparam logic [BIAS_UA_W-1:0] BIAS_UA_3 = 11'h5df;

    // ======================================================================
    typedef struct packed {
        logic [MAIN_W-1:0] down_main_current_code;
        logic [MAIN_W-1:0] up_main_current_code;
        logic [TRIM_W-1:0] down_trim_current_code;
        logic [TRIM_W-1:0] up_trim_current_code;
        logic [OFFSET_W-1:0] down_offset_current_code;
        logic [OFFSET_W-1:0] up_offset_current_code;
    } pump_cfg_t;

    typedef struct packed {
        logic mute_when_locked;
        logic force_down;
        logic force_up;
        logic lock_flag_pin_enable;
        logic detector_down_enable;
        logic detector_up_enable;
        logic input_swap;
        logic [DELAY_W-1:0] reset_delay_code;
    } detector_cfg_t;

    typedef struct packed {
        logic [OFFSET_UA_W-1:0] offset_ua;
        logic [TRIM_UA_W-1:0] trim_ua;
        logic [MAIN_UA_W-1:0] main_ua;
    } pump_leg_t;

endpackage

// *** core/pump_leg_decode.sv ***
`timescale 1ns/100ps
`default_nettype none
module pump_leg_decode
    import pump_detector_pkg::*;
(
    input wire logic [OFFSET_W-1:0] offset_code,
    input wire logic [TRIM_W-1:0] trim_code,
    input wire logic [MAIN_W-1:0] main_code,
    output pump_leg_t leg
);

    // ======================================================================
    // code to microampere mapping of one pump leg
    always_comb begin
        leg.offset_ua = OFFSET_UA_W'(offset_code) * OFFSET_STEP_UA;
        leg.trim_ua = TRIM_UA_W'(trim_code) * TRIM_STEP_UA;
        if (main_code >= MAIN_SAT_CODE) begin
            leg.main_ua = MAIN_MAX_UA;
        end else begin
            leg.main_ua = MAIN_UA_W'(main_code) * MAIN_STEP_UA;
        end
    end

endmodule
`default_nettype wire

// *** core/detector_output_gate.sv ***
`timescale 1ns/100ps
`default_nettype none
module detector_output_gate (
    input wire logic raw_pulse,
    input wire logic output_enable,
    input wire logic force_on,
    input wire logic mute_when_locked,
    input wire logic locked,
    output logic gated_pulse
);

    logic permit;

    // ======================================================================
    // with mute_when_locked set, muting applies only while locked; when clear, the enable bits mute regardless of lock
    always_comb begin
        if (mute_when_locked) begin
            permit = !locked || output_enable;
        end else begin
            permit = output_enable;
        end
        gated_pulse = force_on || (raw_pulse && permit);
    end

endmodule
`default_nettype wire

// *** core/pump_detector_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module pump_detector_config
    import pump_detector_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    output logic [DATA_W-1:0] reg_rdata,
    output logic reg_rdata_valid,
    input wire logic charge_pump_enable,
    input wire logic detector_enable,
    input wire logic integer_mode,
    input wire logic locked,
    input wire logic ref_in,
    input wire logic vco_in,
    input wire logic raw_up,
    input wire logic raw_down,
    input wire logic serial_read_active,
    input wire logic serial_read_data,
    output logic detector_ref,
    output logic detector_vco,
    output logic detector_up,
    output logic detector_down,
    output logic [DELAY_W-1:0] reset_delay_code,
    output pump_leg_t up_leg,
    output pump_leg_t down_leg,
    output logic pump_tristate,
    output logic [BIAS_UA_W-1:0] amplifier_bias_ua,
    output logic amplifier_active,
    output logic delay_setting_unsafe,
    output logic lock_serial_out_pin,
    output logic lock_serial_out_pin_oe
);

    // ======================================================================
    // register storage
    pump_cfg_t pump_q;
    pump_cfg_t pump_d;
    logic [BIAS_W-1:0] bias_q;
    logic [BIAS_W-1:0] bias_d;
    detector_cfg_t det_q;
    detector_cfg_t det_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;

    logic hit_pump;
    logic hit_bias;
    logic hit_det;

    always_comb begin
        hit_pump = (reg_addr == ADDR_PUMP_CURRENT_CONFIG);
        hit_bias = (reg_addr == ADDR_PUMP_AMPLIFIER_BIAS);
        hit_det = (reg_addr == ADDR_PHASE_DETECTOR_CONTROL);
    end

    // writes to unmapped addresses are dropped; reserved bits are not stored
    always_comb begin
        pump_d = pump_q;
        bias_d = bias_q;
        det_d = det_q;
        if (reg_write && hit_pump) begin
            pump_d.up_offset_current_code = reg_wdata[PC_UP_OFFSET_LSB +: OFFSET_W];
            pump_d.down_offset_current_code = reg_wdata[PC_DOWN_OFFSET_LSB +: OFFSET_W];
            pump_d.up_trim_current_code = reg_wdata[PC_UP_TRIM_LSB +: TRIM_W];
            pump_d.down_trim_current_code = reg_wdata[PC_DOWN_TRIM_LSB +: TRIM_W];
            pump_d.up_main_current_code = reg_wdata[PC_UP_MAIN_LSB +: MAIN_W];
            pump_d.down_main_current_code = reg_wdata[PC_DOWN_MAIN_LSB +: MAIN_W];
        end
        if (reg_write && hit_bias) begin
            bias_d = reg_wdata[AB_BIAS_LSB +: BIAS_W];
        end
        if (reg_write && hit_det) begin
            det_d.reset_delay_code = reg_wdata[PD_DELAY_LSB +: DELAY_W];
            det_d.input_swap = reg_wdata[PD_SWAP_BIT];
            det_d.detector_up_enable = reg_wdata[PD_UP_EN_BIT];
            det_d.detector_down_enable = reg_wdata[PD_DOWN_EN_BIT];
            det_d.lock_flag_pin_enable = reg_wdata[PD_LOCK_PIN_EN_BIT];
            det_d.force_up = reg_wdata[PD_FORCE_UP_BIT];
            det_d.force_down = reg_wdata[PD_FORCE_DOWN_BIT];
            det_d.mute_when_locked = reg_wdata[PD_MUTE_LOCKED_BIT];
        end
    end

    // ======================================================================
    // read path: one cycle latency, unmapped and reserved bits read zero
    always_comb begin
        rdata_d = rdata_q;
        rvalid_d = reg_read;
        if (reg_read) begin
            rdata_d = '0;
            if (hit_pump) begin
                rdata_d[PC_UP_OFFSET_LSB +: OFFSET_W] = pump_q.up_offset_current_code;
                rdata_d[PC_DOWN_OFFSET_LSB +: OFFSET_W] = pump_q.down_offset_current_code;
                rdata_d[PC_UP_TRIM_LSB +: TRIM_W] = pump_q.up_trim_current_code;
                rdata_d[PC_DOWN_TRIM_LSB +: TRIM_W] = pump_q.down_trim_current_code;
                rdata_d[PC_UP_MAIN_LSB +: MAIN_W] = pump_q.up_main_current_code;
                rdata_d[PC_DOWN_MAIN_LSB +: MAIN_W] = pump_q.down_main_current_code;
                rdata_d[PC_RSVD_LO_LSB +: PC_RSVD_LO_W] = '0;
                rdata_d[PC_RSVD_MID_LSB +: PC_RSVD_MID_W] = '0;
            end
            if (hit_bias) begin
                rdata_d[AB_BIAS_LSB +: BIAS_W] = bias_q;
            end
            if (hit_det) begin
                rdata_d[PD_DELAY_LSB +: DELAY_W] = det_q.reset_delay_code;
                rdata_d[PD_SWAP_BIT] = det_q.input_swap;
                rdata_d[PD_UP_EN_BIT] = det_q.detector_up_enable;
                rdata_d[PD_DOWN_EN_BIT] = det_q.detector_down_enable;
                rdata_d[PD_LOCK_PIN_EN_BIT] = det_q.lock_flag_pin_enable;
                rdata_d[PD_FORCE_UP_BIT] = det_q.force_up;
                rdata_d[PD_FORCE_DOWN_BIT] = det_q.force_down;
                rdata_d[PD_MUTE_LOCKED_BIT] = det_q.mute_when_locked;
            end
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pump_q.up_offset_current_code <= RST_OFFSET;
            pump_q.down_offset_current_code <= RST_OFFSET;
            pump_q.up_trim_current_code <= RST_TRIM;
            pump_q.down_trim_current_code <= RST_TRIM;
            pump_q.up_main_current_code <= RST_MAIN;
            pump_q.down_main_current_code <= RST_MAIN;
            bias_q <= RST_BIAS;
            det_q.reset_delay_code <= RST_DELAY;
            det_q.input_swap <= RST_SWAP;
            det_q.detector_up_enable <= RST_UP_EN;
            det_q.detector_down_enable <= RST_DOWN_EN;
            det_q.lock_flag_pin_enable <= RST_LOCK_PIN_EN;
            det_q.force_up <= RST_FORCE;
            det_q.force_down <= RST_FORCE;
            det_q.mute_when_locked <= RST_MUTE_LOCKED;
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            pump_q <= pump_d;
            bias_q <= bias_d;
            det_q <= det_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    always_comb begin
        reg_rdata = rdata_q;
        reg_rdata_valid = rvalid_q;
    end

    // ======================================================================
    // pump current decode
    pump_leg_t up_leg_c;
    pump_leg_t down_leg_c;

    pump_leg_decode u_up_leg (
        .offset_code(pump_q.up_offset_current_code),
        .trim_code(pump_q.up_trim_current_code),
        .main_code(pump_q.up_main_current_code),
        .leg(up_leg_c)
    );

    pump_leg_decode u_down_leg (
        .offset_code(pump_q.down_offset_current_code),
        .trim_code(pump_q.down_trim_current_code),
        .main_code(pump_q.down_main_current_code),
        .leg(down_leg_c)
    );

    // ======================================================================
    // detector output gating
    logic up_gated_c;
    logic down_gated_c;

    detector_output_gate u_up_gate (
        .raw_pulse(raw_up),
        .output_enable(det_q.detector_up_enable),
        .force_on(det_q.force_up),
        .mute_when_locked(det_q.mute_when_locked),
        .locked(locked),
        .gated_pulse(up_gated_c)
    );

    detector_output_gate u_down_gate (
        .raw_pulse(raw_down),
        .output_enable(det_q.detector_down_enable),
        .force_on(det_q.force_down),
        .mute_when_locked(det_q.mute_when_locked),
        .locked(locked),
        .gated_pulse(down_gated_c)
    );

    // ======================================================================
    // registered outputs toward the analog side
    logic [BIAS_UA_W-1:0] bias_ua_c;
    pump_leg_t up_leg_q;
    pump_leg_t down_leg_q;
    logic tristate_q;
    logic tristate_d;
    logic [BIAS_UA_W-1:0] bias_ua_q;
    logic amp_active_q;
    logic unsafe_q;
    logic unsafe_d;
    logic ref_q;
    logic ref_d;
    logic vco_q;
    logic vco_d;
    logic up_q;
    logic down_q;
    logic pin_q;
    logic pin_d;
    logic pin_oe_q;
    logic pin_oe_d;

    always_comb begin
        unique case (bias_q)
            2'h0: bias_ua_c = BIAS_UA_0;
            2'h1: bias_ua_c = BIAS_UA_1;
            2'h2: bias_ua_c = BIAS_UA_2;
            2'h3: bias_ua_c = BIAS_UA_3;
        endcase
        // both main current codes at 0 with the detector off float the pump output; offset and trim codes are ignored
        tristate_d = (pump_q.up_main_current_code == RST_MAIN)
            && (pump_q.down_main_current_code == RST_MAIN)
            && !detector_enable;
        // flag only; the delay code still goes out as written
        unsafe_d = integer_mode && (det_q.reset_delay_code == DELAY_TOO_SHORT);
        ref_d = det_q.input_swap ? vco_in : ref_in;
        vco_d = det_q.input_swap ? ref_in : vco_in;
        // serial read data owns the pin while a read is in progress
        if (serial_read_active) begin
            pin_d = serial_read_data;
            pin_oe_d = 1'b1;
        end else begin
            pin_d = det_q.lock_flag_pin_enable && locked;
            pin_oe_d = det_q.lock_flag_pin_enable;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            up_leg_q <= '0;
            down_leg_q <= '0;
            tristate_q <= 1'b0;
            bias_ua_q <= BIAS_UA_0;
            amp_active_q <= 1'b0;
            unsafe_q <= 1'b0;
            ref_q <= 1'b0;
            vco_q <= 1'b0;
            up_q <= 1'b0;
            down_q <= 1'b0;
            pin_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            up_leg_q <= up_leg_c;
            down_leg_q <= down_leg_c;
            tristate_q <= tristate_d;
            bias_ua_q <= bias_ua_c;
            amp_active_q <= charge_pump_enable;
            unsafe_q <= unsafe_d;
            ref_q <= ref_d;
            vco_q <= vco_d;
            up_q <= up_gated_c;
            down_q <= down_gated_c;
            pin_q <= pin_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    always_comb begin
        up_leg = up_leg_q;
        down_leg = down_leg_q;
        pump_tristate = tristate_q;
        amplifier_bias_ua = bias_ua_q;
        amplifier_active = amp_active_q;
        delay_setting_unsafe = unsafe_q;
        reset_delay_code = det_q.reset_delay_code;
        detector_ref = ref_q;
        detector_vco = vco_q;
        detector_up = up_q;
        detector_down = down_q;
        lock_serial_out_pin = pin_q;
        lock_serial_out_pin_oe = pin_oe_q;
    end

endmodule
`default_nettype wire

// *** sim/pump_detector_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module pump_detector_checker
    import pump_detector_pkg::*;
(
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_rdata_valid,
    input wire logic charge_pump_enable,
    input wire logic locked,
    input wire logic ref_in,
    input wire logic vco_in,
    input wire logic raw_up,
    input wire logic raw_down,
    input wire logic serial_read_active,
    input wire logic detector_ref,
    input wire logic detector_up,
    input wire logic detector_down,
    input wire logic [DELAY_W-1:0] reset_delay_code,
    input wire logic amplifier_active,
    input wire logic lock_serial_out_pin_oe
);
    // ======================================================================
    // shadow of the detector control register, rebuilt from port writes
    detector_cfg_t pd_q;
    detector_cfg_t pd_d;
    logic exp_up;
    logic exp_down;
    logic exp_ref;

    always_comb begin
        pd_d = pd_q;
        if (reg_write && reg_addr == ADDR_PHASE_DETECTOR_CONTROL) begin
            pd_d = reg_wdata[9:0];
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pd_q <= 10'h070;
        end else begin
            pd_q <= pd_d;
        end
    end

    assign exp_up = pd_q.force_up | raw_up & (pd_q.mute_when_locked ?
        (!locked | pd_q.detector_up_enable) : pd_q.detector_up_enable);
    assign exp_down = pd_q.force_down | raw_down & (pd_q.mute_when_locked ?
        (!locked | pd_q.detector_down_enable) : pd_q.detector_down_enable);
    assign exp_ref = pd_q.input_swap ? vco_in : ref_in;

    // ======================================================================
    // properties
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    AST_READ_ANSWER: assert property (reg_read |=> reg_rdata_valid)
        else $error("read strobe not answered");
    AST_VALID_PULSE: assert property (!reg_read |=> !reg_rdata_valid)
        else $error("read valid without a read");
    AST_DELAY_FIELD: assert property (reset_delay_code == pd_q.reset_delay_code)
        else $error("delay code differs from last write");
    AST_AMP_FOLLOWS: assert property (1 |=> amplifier_active == $past(charge_pump_enable))
        else $error("amplifier active does not follow pump enable");
    AST_UP_GATE: assert property (1 |=> detector_up == $past(exp_up))
        else $error("up output gating wrong");
    AST_DOWN_GATE: assert property (1 |=> detector_down == $past(exp_down))
        else $error("down output gating wrong");
    AST_SWAP: assert property (1 |=> detector_ref == $past(exp_ref))
        else $error("detector input swap wrong");
    AST_PIN_OE: assert property (!serial_read_active |=>
        lock_serial_out_pin_oe == $past(pd_q.lock_flag_pin_enable))
        else $error("lock pin drive enable wrong");

    cover property (reg_read ##1 reg_rdata_valid);
    cover property (pd_q.mute_when_locked && locked && raw_up);
    cover property (pd_q.input_swap && ref_in != vco_in);
endmodule

bind pump_detector_config pump_detector_checker chk (.clock, .sys_rst, .reg_write,
    .reg_read, .reg_addr, .reg_wdata, .reg_rdata_valid, .charge_pump_enable, .locked,
    .ref_in, .vco_in, .raw_up, .raw_down, .serial_read_active, .detector_ref,
    .detector_up, .detector_down, .reset_delay_code, .amplifier_active,
    .lock_serial_out_pin_oe);
`default_nettype wire

// *** sim/tb_pump_detector_config.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_pump_detector_config
    import pump_detector_pkg::*;
;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [23:0] reg_wdata = 24'h000000;
    logic charge_pump_enable = 1'b1;
    logic detector_enable = 1'b1;
    logic integer_mode = 1'b1;
    logic locked = 1'b0;
    logic ref_in = 1'b0;
    logic vco_in = 1'b0;
    logic raw_up = 1'b0;
    logic raw_down = 1'b0;
    logic serial_read_active = 1'b0;
    logic serial_read_data = 1'b0;
    logic [23:0] reg_rdata;
    logic reg_rdata_valid, detector_ref, detector_vco, detector_up, detector_down;
    logic [2:0] reset_delay_code;
    pump_leg_t up_leg, down_leg;
    logic pump_tristate, amplifier_active, delay_setting_unsafe;
    logic [10:0] amplifier_bias_ua;
    logic lock_serial_out_pin, lock_serial_out_pin_oe;
    int error_cnt = 0;
    int checks = 0;

    always #5 clock = ~clock;

    pump_detector_config dut (.clock, .sys_rst, .reg_write, .reg_read, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rdata_valid, .charge_pump_enable, .detector_enable,
        .integer_mode, .locked, .ref_in, .vco_in, .raw_up, .raw_down, .serial_read_active,
        .serial_read_data, .detector_ref, .detector_vco, .detector_up, .detector_down,
        .reset_delay_code, .up_leg, .down_leg, .pump_tristate, .amplifier_bias_ua,
        .amplifier_active, .delay_setting_unsafe, .lock_serial_out_pin,
        .lock_serial_out_pin_oe);

    // ======================================================================
    // shared helpers; every task except finish_test from the watchdog starts and ends 1 ns after a rising edge
    task automatic finish_test;
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    // returns one edge after the register edge, so registered outputs have settled
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        reg_write = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        step(1);
        reg_write = 1'b0;
        step(1);
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] e);
        reg_read = 1'b1;
        reg_addr = a;
        step(1);
        reg_read = 1'b0;
        chk(reg_rdata_valid, 1'b1);
        chk(reg_rdata, e);
        step(1);
        chk(reg_rdata_valid, 1'b0);
    endtask

    function automatic logic [11:0] main_ua(input int c);
        return (c >= 4) ? 12'h7d0 : 12'(500 * c);
    endfunction

    // ======================================================================
    // scenarios
    task automatic t_defaults;
        rd(ADDR_PUMP_CURRENT_CONFIG, 24'h000000);
        rd(ADDR_PUMP_AMPLIFIER_BIAS, 24'h000000);
        rd(ADDR_PHASE_DETECTOR_CONTROL, 24'h000070);
        chk(amplifier_bias_ua, 11'h21c);
        chk(lock_serial_out_pin_oe, 1'b1);
    endtask

    task automatic t_pump;
        logic [23:0] w;
        for (int i = 0; i < 8; i++) begin
            w = {3'(7-i), 3'(i), 4'(14-2*i), 4'(2*i+1), 3'(7-i), 2'h0, 3'(i), 2'h0};
            wr(ADDR_PUMP_CURRENT_CONFIG, w);
            chk(up_leg, {9'(55*i), 7'(14*i+7), main_ua(i)});
            chk(down_leg, {9'(385-55*i), 7'(98-14*i), main_ua(7-i)});
            rd(ADDR_PUMP_CURRENT_CONFIG, w);
        end
        wr(ADDR_PUMP_CURRENT_CONFIG, 24'h000000);
        detector_enable = 1'b0;
        step(1);
        chk(pump_tristate, 1'b1);
        detector_enable = 1'b1;
        step(1);
        chk(pump_tristate, 1'b0);
    endtask

    task automatic t_bias;
        logic [10:0] tbl [4] = '{11'h21c, 11'h2b1, 11'h3af, 11'h5df};
        for (int j = 0; j < 4; j++) begin
            wr(ADDR_PUMP_AMPLIFIER_BIAS, 24'(j));
            chk(amplifier_bias_ua, tbl[j]);
            rd(ADDR_PUMP_AMPLIFIER_BIAS, 24'(j));
        end
        charge_pump_enable = 1'b0;
        step(1);
        chk(amplifier_active, 1'b0);
        charge_pump_enable = 1'b1;
        step(1);
        chk(amplifier_active, 1'b1);
    endtask

    task automatic t_detector;
        logic [3:0] k;
        logic sw;
        raw_up = 1'b1;
        raw_down = 1'b1;
        ref_in = 1'b1;
        vco_in = 1'b0;
        for (int n = 0; n < 16; n++) begin
            k = 4'(n);
            sw = k[0] ^ k[1];
            locked = k[2];
            wr(ADDR_PHASE_DETECTOR_CONTROL, {14'h0, k[0], 1'b0, k[3], 1'b1, !k[1], k[1], sw, k[2:0]});
            chk(detector_up, k[3] | (k[0] ? (!k[2] | k[1]) : k[1]));
            chk(detector_down, k[0] ? (!k[2] | !k[1]) : !k[1]);
            chk({detector_ref, detector_vco}, {!sw, sw});
            chk(reset_delay_code, k[2:0]);
            chk(delay_setting_unsafe, k[2:0] == 3'h0);
        end
        raw_down = 1'b0;
        wr(ADDR_PHASE_DETECTOR_CONTROL, 24'h000100);
        chk(detector_down, 1'b1);
        wr(ADDR_PHASE_DETECTOR_CONTROL, 24'h000070);
        chk(detector_down, 1'b0);
        raw_up = 1'b0;
        integer_mode = 1'b0;
        step(1);
        chk(detector_up, 1'b0);
        chk(delay_setting_unsafe, 1'b0);
        integer_mode = 1'b1;
        raw_up = 1'b1;
    endtask

    task automatic t_pin;
        locked = 1'b1;
        for (int p = 0; p < 2; p++) begin
            wr(ADDR_PHASE_DETECTOR_CONTROL, (p == 1) ? 24'h000070 : 24'h000030);
            chk({lock_serial_out_pin_oe, lock_serial_out_pin}, {1'(p), 1'(p)});
        end
        locked = 1'b0;
        step(1);
        chk(lock_serial_out_pin, 1'b0);
        serial_read_active = 1'b1;
        serial_read_data = 1'b1;
        step(1);
        chk({lock_serial_out_pin_oe, lock_serial_out_pin}, 2'h3);
        serial_read_active = 1'b0;
        serial_read_data = 1'b0;
    endtask

    task automatic t_unmapped_and_reset;
        wr(6'h0c, 24'hffffff);
        rd(6'h0c, 24'h000000);
        rd(ADDR_PHASE_DETECTOR_CONTROL, 24'h000070);
        wr(ADDR_PHASE_DETECTOR_CONTROL, 24'h0003ff);
        wr(ADDR_PUMP_AMPLIFIER_BIAS, 24'h000003);
        wr(ADDR_PUMP_CURRENT_CONFIG, 24'hffff9c);
        sys_rst = 1'b1;
        step(2);
        sys_rst = 1'b0;
        t_defaults();
    endtask

    // ======================================================================
    // main sequence and watchdog
    initial begin
        repeat (50000) @(posedge clock);
        error_cnt++;
        finish_test();
    end

    initial begin
        step(8);
        sys_rst = 1'b0;
        t_defaults();
        t_pump();
        t_bias();
        t_detector();
        t_pin();
        t_unmapped_and_reset();
        finish_test();
    end
endmodule
`default_nettype wire
